// file: rtl/isc_pkg.sv
// Package: register map, field positions and carriers of the status block
package isc_pkg;
  // Register indices on the 3-bit register port
  localparam logic [2:0] OFS_CLK_SEL = 3'h0; // i2c_clock_source_select
  localparam logic [2:0] OFS_TMO_SEL = 3'h1; // bus_timeout_source_select
  localparam logic [2:0] OFS_BUS_STAT = 3'h2; // bus_state_status
  localparam logic [2:0] OFS_BUF_STAT = 3'h3; // buffer_status
  localparam logic [2:0] OFS_ERR = 3'h4; // error_flags_enables
  localparam logic [2:0] OFS_TX_BUF = 3'h5; // transmit_buffer
  localparam logic [2:0] OFS_RX_BUF = 3'h6; // receive_buffer
  localparam logic [2:0] OFS_CTRL = 3'h7; // enable and bus-free time

  // Timing clock codes
  localparam logic [3:0] CLK_SYS_DIV4 = 4'h0;
  localparam logic [3:0] CLK_SYS = 4'h1;
  localparam logic [3:0] CLK_EXT_FIRST = 4'h2;
  localparam logic [3:0] CLK_LAST_VALID = 4'h9;
  localparam logic [1:0] DIV4_LAST = 2'h3;

  // Timeout source codes
  localparam logic [2:0] TMO_RESERVED = 3'h0;
  localparam logic [2:0] TMO_FIRST = 3'h1;

  // Bus state status fields
  localparam int BS_FREE = 7;
  localparam int BS_SLAVE = 6;
  localparam int BS_MASTER = 5;
  localparam int BS_READ = 4;
  localparam int BS_DATA = 3;

  // Buffer status fields
  localparam int BF_TRANSMIT_WRITE_ERROR = 7;
  localparam int BF_TRANSMIT_EMPTY_FLAG = 5;
  localparam int BF_RECEIVE_READ_ERROR = 3;
  localparam int BF_CLR = 2;
  localparam int BF_RECEIVE_FULL_FLAG = 0;

  // Error register fields
  localparam int ER_TMO_IF = 6;
  localparam int ER_COL_IF = 5;
  localparam int ER_NACK_IF = 4;
  localparam int ER_TMO_IE = 2;
  localparam int ER_COL_IE = 1;
  localparam int ER_NACK_IE = 0;

  // Control register fields
  localparam int CT_EN = 7;
  localparam int CT_MULTI = 6;
  localparam int CT_FREE_LO = 0;

  // Bus-free time: 8 pulses shifted left by the field code
  localparam logic [6:0] BUS_FREE_BASE = 7'h08;
  localparam logic TRANSMIT_EMPTY_FLAG_RESET = 1'b1;

  // Kinds of matched received address
  typedef enum logic [1:0] {
    AK_7BIT = 2'b00,
    AK_10LOW = 2'b01,
    AK_10HIGH = 2'b10
  } isc_addr_kind_t;

  // Events from the sequencer and shifter, same clock
  typedef struct packed {
    logic startSent; // master put a Start on the bus
    logic stopSent; // master finished shifting a Stop
    logic addrMatch; // 8th fall of matching received address
    isc_addr_kind_t addrKind;
    logic addrRead; // direction bit of that address
    logic byteDone; // a byte finished on the bus
    logic byteIsData; // that byte was data
    logic nackSeen; // NACK in an active transfer
    logic underflow; // slave_transmit_underflow set
    logic overflow; // slave_receive_overflow set
    logic rxLoad; // shifter loads receive_buffer
    logic [7:0] rxByte;
    logic txTake; // shifter took transmit_buffer
    logic sdaDrivenHigh; // own SDA output released high
  } isc_seq_ev_t;
endpackage

// file: rtl/isc_status_core.sv
// Clock/timeout select, bus status, buffer flags and error flags
//
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module isc_status_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic [7:0] clkSrcIn,
  input wire logic [6:0] tmoSrcIn,
  input isc_pkg::isc_seq_ev_t seqEv,
  output logic moduleEnable,
  output logic multiMaster,
  output logic i2cClkTick,
  output logic goIdle,
  output logic forceNack,
  output logic [7:0] txByte,
  output logic dmaTxReq,
  output logic dmaRxReq,
  output logic rxIrqFlag,
  output logic txIrqFlag,
  output logic errIrq
);
  // Whole state of the block
  typedef struct packed {
    logic sclMeta; // Synchroniser first stages
    logic sclSync;
    logic sclPrev;
    logic sdaMeta;
    logic sdaSync;
    logic sdaPrev;
    logic [7:0] clkMeta;
    logic [7:0] clkSync;
    logic [7:0] clkPrev;
    logic [6:0] tmoMeta;
    logic [6:0] tmoSync;
    logic [6:0] tmoPrev;
    logic [1:0] divCnt; // System clock divide by four
    logic tick;
    logic [3:0] clkSel;
    logic [2:0] timeoutSourceCode;
    logic enable;
    logic multi;
    logic [1:0] busFreeTimeField;
    logic [6:0] freeCnt;
    logic busFreeFlag;
    logic slaveActiveFlag;
    logic masterActiveFlag;
    logic readFlag;
    logic dataFlag;
    logic tenArmed; // 10-bit high+low write seen
    logic [7:0] txBuf;
    logic [7:0] rxBuf;
    logic transmitEmptyFlag;
    logic receiveFullFlag;
    logic transmitWriteError;
    logic receiveReadError;
    logic rxIrq;
    logic txIrq;
    logic timeoutFlag;
    logic collisionFlag;
    logic nackDetectFlag;
    logic timeoutIrqEnable;
    logic collisionIrqEnable;
    logic nackIrqEnable;
    logic errIrq;
    logic goIdle;
    logic forceNack;
    logic dmaTx;
    logic dmaRx;
    logic [7:0] rdData;
  } isc_state_t;

  isc_state_t st_r; // Registered state
  isc_state_t st_nxt; // Next state

  // Decoded conditions of the current cycle
  logic clkValid;
  logic tickNow;
  logic [2:0] extIdx;
  logic [2:0] tmoIdx;
  logic sclRise;
  logic startDet;
  logic stopDet;
  logic linesHigh;
  logic colEv;
  logic tmoEv;
  logic busy;
  logic txWrite;
  logic rxRead;
  logic bufWrite;
  logic errWrite;
  logic ctlWrite;
  logic wErr;
  logic rErr;
  logic [6:0] freeThr;
  logic [6:0] cntInc;

  // Clock source decode; codes above nine give no clock
  assign clkValid = st_r.clkSel <= isc_pkg::CLK_LAST_VALID;
  assign extIdx = 3'(st_r.clkSel - isc_pkg::CLK_EXT_FIRST);

  // Selected timing pulse, one cycle each
  always_comb begin
    tickNow = 1'b0;
    case (st_r.clkSel)
      isc_pkg::CLK_SYS_DIV4: tickNow = st_r.divCnt == isc_pkg::DIV4_LAST;
      isc_pkg::CLK_SYS: tickNow = 1'b1;
      default: begin
        // External sources: rising edge of synced level
        if (clkValid) begin
          tickNow = st_r.clkSync[extIdx] & ~st_r.clkPrev[extIdx];
        end
      end
    endcase
  end

  // Timeout source: code zero selects nothing
  assign tmoIdx = st_r.timeoutSourceCode - isc_pkg::TMO_FIRST;
  assign busy = st_r.slaveActiveFlag | st_r.masterActiveFlag;
  assign tmoEv = st_r.enable && busy
    && st_r.timeoutSourceCode != isc_pkg::TMO_RESERVED
    && st_r.tmoSync[tmoIdx] && !st_r.tmoPrev[tmoIdx];

  // Bus line events from synced pins
  assign sclRise = st_r.sclSync & ~st_r.sclPrev;
  assign startDet = st_r.sclSync & st_r.sclPrev
    & st_r.sdaPrev & ~st_r.sdaSync;
  assign stopDet = st_r.sclSync & st_r.sclPrev
    & ~st_r.sdaPrev & st_r.sdaSync;
  assign linesHigh = st_r.sclSync & st_r.sdaSync;

  // Own SDA released high but line low on SCL rise
  assign colEv = st_r.enable && sclRise
    && seqEv.sdaDrivenHigh && !st_r.sdaSync;

  // Bus-free threshold 8, 16, 32 or 64 pulses
  assign freeThr = isc_pkg::BUS_FREE_BASE << st_r.busFreeTimeField;
  assign cntInc = st_r.freeCnt + 7'h01;

  // Register strobes
  assign txWrite = regWr && regAddr == isc_pkg::OFS_TX_BUF;
  assign rxRead = regRd && regAddr == isc_pkg::OFS_RX_BUF;
  assign bufWrite = regWr && regAddr == isc_pkg::OFS_BUF_STAT;
  assign errWrite = regWr && regAddr == isc_pkg::OFS_ERR;
  assign ctlWrite = regWr && regAddr == isc_pkg::OFS_CTRL;
  assign wErr = txWrite && !st_r.transmitEmptyFlag;
  assign rErr = rxRead && !st_r.receiveFullFlag;

  // Next state of the whole block
  always_comb begin
    st_nxt = st_r;
    // Two-stage synchronisers, then edge history
    st_nxt.sclMeta = sclIn;
    st_nxt.sclSync = st_r.sclMeta;
    st_nxt.sclPrev = st_r.sclSync;
    st_nxt.sdaMeta = sdaIn;
    st_nxt.sdaSync = st_r.sdaMeta;
    st_nxt.sdaPrev = st_r.sdaSync;
    st_nxt.clkMeta = clkSrcIn;
    st_nxt.clkSync = st_r.clkMeta;
    st_nxt.clkPrev = st_r.clkSync;
    st_nxt.tmoMeta = tmoSrcIn;
    st_nxt.tmoSync = st_r.tmoMeta;
    st_nxt.tmoPrev = st_r.tmoSync;
    st_nxt.divCnt = st_r.divCnt + 2'h1;
    st_nxt.tick = tickNow;

    // Configuration writes
    if (regWr && regAddr == isc_pkg::OFS_CLK_SEL) begin
      st_nxt.clkSel = regWdata[3:0];
    end
    if (regWr && regAddr == isc_pkg::OFS_TMO_SEL) begin
      st_nxt.timeoutSourceCode = regWdata[2:0];
    end
    if (ctlWrite) begin
      st_nxt.enable = regWdata[isc_pkg::CT_EN];
      st_nxt.multi = regWdata[isc_pkg::CT_MULTI];
      st_nxt.busFreeTimeField = regWdata[isc_pkg::CT_FREE_LO +: 2];
    end

    // Bus-free counter; restarts whenever a line drops
    if (!linesHigh || !clkValid) begin
      st_nxt.freeCnt = 7'h00;
    end else if (tickNow && st_r.freeCnt < freeThr) begin
      st_nxt.freeCnt = cntInc;
    end
    st_nxt.busFreeFlag = linesHigh && clkValid
      && st_nxt.freeCnt >= freeThr;

    // Matched received address
    if (seqEv.addrMatch && st_r.enable) begin
      st_nxt.readFlag = seqEv.addrRead;
      case (seqEv.addrKind)
        isc_pkg::AK_7BIT: st_nxt.slaveActiveFlag = 1'b1;
        isc_pkg::AK_10LOW: begin
          st_nxt.slaveActiveFlag = 1'b1;
          st_nxt.tenArmed = !seqEv.addrRead;
        end
        isc_pkg::AK_10HIGH: begin
          // High with read counts only after high+low write
          if (seqEv.addrRead && st_r.tenArmed) begin
            st_nxt.slaveActiveFlag = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // Bus conditions and errors end slave activity
    if (startDet || stopDet || tmoEv || colEv) begin
      st_nxt.slaveActiveFlag = 1'b0;
    end
    // Restart keeps the 10-bit history, Stop drops it
    if (stopDet || tmoEv || colEv || !st_r.enable) begin
      st_nxt.tenArmed = 1'b0;
    end

    // Master activity
    if (seqEv.startSent && st_r.enable) begin
      st_nxt.masterActiveFlag = 1'b1;
    end
    if (colEv || seqEv.stopSent) begin
      st_nxt.masterActiveFlag = 1'b0;
    end
    // Disable drops all activity
    if (!st_r.enable) begin
      st_nxt.slaveActiveFlag = 1'b0;
      st_nxt.masterActiveFlag = 1'b0;
    end

    // Kind of last byte on the bus
    if (seqEv.byteDone) begin
      st_nxt.dataFlag = seqEv.byteIsData;
    end

    // Software side of buffer status; clears go first
    if (bufWrite) begin
      st_nxt.transmitWriteError = regWdata[isc_pkg::BF_TRANSMIT_WRITE_ERROR];
      st_nxt.receiveReadError = regWdata[isc_pkg::BF_RECEIVE_READ_ERROR];
      if (regWdata[isc_pkg::BF_CLR]) begin
        st_nxt.transmitEmptyFlag = 1'b1;
        st_nxt.receiveFullFlag = 1'b0;
        st_nxt.rxIrq = 1'b0;
        st_nxt.txIrq = 1'b0;
      end
    end
    // Receive read frees the buffer
    if (rxRead && st_r.receiveFullFlag) begin
      st_nxt.receiveFullFlag = 1'b0;
      st_nxt.rxIrq = 1'b0;
    end
    // Shifter took the byte; a write below may refill it
    if (seqEv.txTake) begin
      st_nxt.transmitEmptyFlag = 1'b1;
      st_nxt.txIrq = 1'b1;
    end
    // Write to a full buffer keeps the old byte
    if (txWrite && st_r.transmitEmptyFlag) begin
      st_nxt.txBuf = regWdata;
      st_nxt.transmitEmptyFlag = 1'b0;
      st_nxt.txIrq = 1'b0;
    end
    // Arrival wins over a same-cycle read or clear
    if (seqEv.rxLoad) begin
      st_nxt.rxBuf = seqEv.rxByte;
      st_nxt.receiveFullFlag = 1'b1;
      st_nxt.rxIrq = 1'b1;
    end
    // Hardware sets of the error bits win over writes
    if (wErr) begin
      st_nxt.transmitWriteError = 1'b1;
    end
    if (rErr) begin
      st_nxt.receiveReadError = 1'b1;
    end
    // Flags held in reset state while disabled
    if (!st_r.enable) begin
      st_nxt.transmitEmptyFlag = 1'b1;
      st_nxt.receiveFullFlag = 1'b0;
    end

    // Error register: write first, hardware sets win
    if (errWrite) begin
      st_nxt.timeoutFlag = regWdata[isc_pkg::ER_TMO_IF];
      st_nxt.collisionFlag = regWdata[isc_pkg::ER_COL_IF];
      st_nxt.nackDetectFlag = regWdata[isc_pkg::ER_NACK_IF];
      st_nxt.timeoutIrqEnable = regWdata[isc_pkg::ER_TMO_IE];
      st_nxt.collisionIrqEnable = regWdata[isc_pkg::ER_COL_IE];
      st_nxt.nackIrqEnable = regWdata[isc_pkg::ER_NACK_IE];
    end
    if (tmoEv) begin
      st_nxt.timeoutFlag = 1'b1;
    end
    if (colEv) begin
      st_nxt.collisionFlag = 1'b1;
    end
    // NACKs to foreign addresses never reach here: not busy
    if ((seqEv.nackSeen && busy) || wErr || rErr
        || seqEv.underflow || seqEv.overflow) begin
      st_nxt.nackDetectFlag = 1'b1;
    end

    // Outputs, each a flop
    st_nxt.errIrq = (st_r.timeoutFlag & st_r.timeoutIrqEnable)
      | (st_r.collisionFlag & st_r.collisionIrqEnable)
      | (st_r.nackDetectFlag & st_r.nackIrqEnable);
    st_nxt.goIdle = tmoEv | colEv;
    st_nxt.forceNack = st_r.transmitWriteError
      | st_r.receiveReadError;
    st_nxt.dmaTx = st_nxt.transmitEmptyFlag;
    st_nxt.dmaRx = st_nxt.receiveFullFlag;

    // Read data, valid the cycle after the strobe
    st_nxt.rdData = 8'h00;
    if (regRd) begin
      case (regAddr)
        isc_pkg::OFS_CLK_SEL: st_nxt.rdData = {4'h0, st_r.clkSel};
        isc_pkg::OFS_TMO_SEL: begin
          st_nxt.rdData = {5'h00, st_r.timeoutSourceCode};
        end
        isc_pkg::OFS_BUS_STAT: begin
          st_nxt.rdData[isc_pkg::BS_FREE] = st_r.busFreeFlag;
          st_nxt.rdData[isc_pkg::BS_SLAVE] = st_r.slaveActiveFlag;
          st_nxt.rdData[isc_pkg::BS_MASTER] = st_r.masterActiveFlag;
          st_nxt.rdData[isc_pkg::BS_READ] = st_r.readFlag;
          st_nxt.rdData[isc_pkg::BS_DATA] = st_r.dataFlag;
        end
        isc_pkg::OFS_BUF_STAT: begin
          // Clear-buffer bit always reads zero
          st_nxt.rdData[isc_pkg::BF_TRANSMIT_WRITE_ERROR] = st_r.transmitWriteError;
          st_nxt.rdData[isc_pkg::BF_TRANSMIT_EMPTY_FLAG] = st_r.transmitEmptyFlag;
          st_nxt.rdData[isc_pkg::BF_RECEIVE_READ_ERROR] = st_r.receiveReadError;
          st_nxt.rdData[isc_pkg::BF_RECEIVE_FULL_FLAG] = st_r.receiveFullFlag;
        end
        isc_pkg::OFS_ERR: begin
          st_nxt.rdData[isc_pkg::ER_TMO_IF] = st_r.timeoutFlag;
          st_nxt.rdData[isc_pkg::ER_COL_IF] = st_r.collisionFlag;
          st_nxt.rdData[isc_pkg::ER_NACK_IF] = st_r.nackDetectFlag;
          st_nxt.rdData[isc_pkg::ER_TMO_IE] = st_r.timeoutIrqEnable;
          st_nxt.rdData[isc_pkg::ER_COL_IE] = st_r.collisionIrqEnable;
          st_nxt.rdData[isc_pkg::ER_NACK_IE] = st_r.nackIrqEnable;
        end
        isc_pkg::OFS_RX_BUF: st_nxt.rdData = st_r.rxBuf;
        isc_pkg::OFS_CTRL: begin
          st_nxt.rdData[isc_pkg::CT_EN] = st_r.enable;
          st_nxt.rdData[isc_pkg::CT_MULTI] = st_r.multi;
          st_nxt.rdData[isc_pkg::CT_FREE_LO +: 2] = st_r.busFreeTimeField;
        end
        default: st_nxt.rdData = 8'h00; // Transmit buffer is write-only
      endcase
    end
  end

  // State register, synchronous reset to constants
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.transmitEmptyFlag <= isc_pkg::TRANSMIT_EMPTY_FLAG_RESET;
      st_r.dmaTx <= isc_pkg::TRANSMIT_EMPTY_FLAG_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Ports straight from the state flops
  assign regRdata = st_r.rdData;
  assign moduleEnable = st_r.enable;
  assign multiMaster = st_r.multi;
  assign i2cClkTick = st_r.tick;
  assign goIdle = st_r.goIdle;
  assign forceNack = st_r.forceNack;
  assign txByte = st_r.txBuf;
  assign dmaTxReq = st_r.dmaTx;
  assign dmaRxReq = st_r.dmaRx;
  assign rxIrqFlag = st_r.rxIrq;
  assign txIrqFlag = st_r.txIrq;
  assign errIrq = st_r.errIrq;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_free_no_clk: assert property (!clkValid |=> !st_r.busFreeFlag)
    else $error("bus free set without clock");
  chk_free_line_low: assert property (
    (!st_r.sclSync || !st_r.sdaSync) |=> !st_r.busFreeFlag)
    else $error("bus free while a line is low");
  chk_slave_cond_clear: assert property (
    (startDet || stopDet) |=> !st_r.slaveActiveFlag)
    else $error("slave active survived Start or Stop");
  chk_master_start_set: assert property (
    (seqEv.startSent && st_r.enable && !colEv && !seqEv.stopSent)
    |=> st_r.masterActiveFlag)
    else $error("master active not set on Start");
  chk_transmit_write_error_on_full: assert property (
    txWrite && !st_r.transmitEmptyFlag |=> st_r.transmitWriteError
    ##1 st_r.forceNack)
    else $error("write to full buffer missed");
  chk_receive_read_error_on_empty: assert property (
    rxRead && !st_r.receiveFullFlag |=> st_r.receiveReadError)
    else $error("read of empty buffer missed");
  chk_clear_bufs: assert property (
    bufWrite && regWdata[isc_pkg::BF_CLR] && !seqEv.rxLoad
    && !seqEv.txTake |=> st_r.transmitEmptyFlag
    && !st_r.receiveFullFlag && !st_r.rxIrq && !st_r.txIrq)
    else $error("clear buffer incomplete");
  chk_disabled_hold: assert property (
    !st_r.enable && !$past(st_r.enable) |->
    st_r.transmitEmptyFlag && !st_r.receiveFullFlag)
    else $error("buffer flags moved while disabled");
  chk_collision_idle: assert property (
    colEv |=> st_r.collisionFlag && st_r.goIdle
    && !st_r.masterActiveFlag)
    else $error("collision not handled");
  chk_err_irq_or: assert property (
    st_r.collisionFlag && st_r.collisionIrqEnable |=> st_r.errIrq)
    else $error("enabled error flag without irq");
  chk_read_latency: assert property (
    regRd && regAddr == isc_pkg::OFS_BUS_STAT |=>
    regRdata[isc_pkg::BS_MASTER] == $past(st_r.masterActiveFlag))
    else $error("status read data wrong");

  cov_bus_free: cover property (!st_r.busFreeFlag ##1 st_r.busFreeFlag);
  cov_collision: cover property (colEv);
  cov_slave_set: cover property (seqEv.addrMatch ##1 st_r.slaveActiveFlag);
  cov_timeout: cover property (tmoEv ##1 st_r.timeoutFlag);
endmodule

// file: tb/isc_bus_peer.sv
// Peer masters and slaves on the open-drain bus lines
`timescale 1ns/1ps
module isc_bus_peer (
  input wire logic clk_sys,
  output logic sclLine,
  output logic sdaLine
);
  // Pulled-up lines: a released line reads high
  logic sclLow = 1'b0;
  logic sdaLow = 1'b0;
  assign sclLine = ~sclLow;
  assign sdaLine = ~sdaLow;
  // Set both line levels, then hold them past the input synchronisers
  task automatic drive(input logic scl, input logic sda);
    @(posedge clk_sys);
    sclLow <= ~scl;
    sdaLow <= ~sda;
    repeat (6) @(posedge clk_sys);
  endtask
  // Stop: SDA rises while SCL is high
  task automatic stop_cond();
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the status and buffer-flag block
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] EN = 8'h80; // Enable bit of control
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic sclIn;
  logic sdaIn;
  logic linkClk = 1'b0; // Timer source at link rate
  logic [6:0] tmoSrcIn = 7'h00;
  isc_pkg::isc_seq_ev_t seqEv = '0;
  logic moduleEnable;
  logic multiMaster;
  logic i2cClkTick;
  logic goIdle;
  logic forceNack;
  logic [7:0] txByte;
  logic dmaTxReq;
  logic dmaRxReq;
  logic rxIrqFlag;
  logic txIrqFlag;
  logic errIrq;
  int fails = 0;
  int checked = 0;
  int ticks = 0; // Timing ticks seen
  int idles = 0; // Idle pulses seen
  int t0;
  logic [7:0] d;
  logic [7:0] b;
  logic r;
  isc_pkg::isc_seq_ev_t e;

  always #2 clk_sys = ~clk_sys;
  // Link clock, phase unrelated to the system clock
  initial begin
    #13;
    forever #40 linkClk = ~linkClk;
  end
  // Pulse counters, sampled mid-cycle where outputs have settled
  always @(negedge clk_sys) begin
    if (i2cClkTick === 1'b1) ticks++;
    if (goIdle === 1'b1) idles++;
  end

  // Even source bits idle, so a wrong code-to-bit mapping shows
  isc_status_core isc_status_core_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .sclIn(sclIn), .sdaIn(sdaIn),
    .clkSrcIn({4{linkClk, 1'b0}}), .tmoSrcIn(tmoSrcIn), .seqEv(seqEv),
    .moduleEnable(moduleEnable), .multiMaster(multiMaster),
    .i2cClkTick(i2cClkTick), .goIdle(goIdle), .forceNack(forceNack),
    .txByte(txByte), .dmaTxReq(dmaTxReq), .dmaRxReq(dmaRxReq),
    .rxIrqFlag(rxIrqFlag), .txIrqFlag(txIrqFlag), .errIrq(errIrq));
  isc_bus_peer isc_bus_peer_inst (.clk_sys(clk_sys), .sclLine(sclIn),
    .sdaLine(sdaIn));

  // Register write, one strobe cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk_sys);
    regWr <= 1'b0;
    #1;
  endtask
  // Register read, data only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
    checked++;
    if (g !== x) begin
      fails++;
      $display("ERROR %s expected %h seen %h", s, x, g);
    end
  endtask
  // Ticks in 160 cycles: divide by four, every cycle, odd link codes
  function automatic logic [7:0] exp_ticks(input int c);
    return (c == 0) ? 8'h28 : (c == 1) ? 8'hA0
      : (c < 10 && c % 2 == 1) ? 8'h08 : 8'h00;
  endfunction
  // Error request: any flag together with its own enable
  function automatic logic [7:0] exp_irq(input logic [7:0] v);
    return 8'(|(v[6:4] & v[2:0]));
  endfunction
  // Read and compare under a mask
  task automatic rdc(input logic [2:0] a, input logic [7:0] m,
    input logic [7:0] x);
    logic [7:0] v;
    rd(a, v);
    chk($sformatf("reg%0d", a), x & m, v & m);
  endtask
  // One-cycle sequencer event
  task automatic ev(input isc_pkg::isc_seq_ev_t s);
    @(posedge clk_sys);
    seqEv <= s;
    @(posedge clk_sys);
    seqEv <= '0;
    #1;
  endtask
  // Timeout source pulse, long enough for the synchroniser
  task automatic tmo(input logic [6:0] m);
    @(posedge clk_sys);
    tmoSrcIn <= m;
    repeat (6) @(posedge clk_sys);
    tmoSrcIn <= 7'h00;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog, well beyond the expected run
  initial begin
    repeat (30000) @(posedge clk_sys);
    fails++;
    print_verdict();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h35eb8a98));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(isc_pkg::OFS_BUF_STAT, 8'hFF, 8'h20);
    wr(isc_pkg::OFS_CLK_SEL, 8'hFF);
    rdc(isc_pkg::OFS_CLK_SEL, 8'hFF, 8'h0F);
    wr(isc_pkg::OFS_TMO_SEL, 8'hFF);
    rdc(isc_pkg::OFS_TMO_SEL, 8'hFF, 8'h07);
    rdc(isc_pkg::OFS_TX_BUF, 8'hFF, 8'h00);
    wr(isc_pkg::OFS_CTRL, EN);
    // Every clock code: tick count over a 160-cycle span
    for (int c = 0; c < 16; c++) begin
      wr(isc_pkg::OFS_CLK_SEL, 8'(c));
      repeat (8) @(posedge clk_sys);
      t0 = ticks;
      repeat (160) @(posedge clk_sys);
      chk("ticks", exp_ticks(c), 8'(ticks - t0));
    end
    $display("test clock select done");
    // Bus-free time for every field code, ticks every 20 cycles
    wr(isc_pkg::OFS_CLK_SEL, 8'h03);
    for (int f = 0; f < 4; f++) begin
      wr(isc_pkg::OFS_CTRL, EN | 8'(f));
      isc_bus_peer_inst.stop_cond();
      repeat ((8 << f) * 10) @(posedge clk_sys);
      rdc(isc_pkg::OFS_BUS_STAT, 8'h80, 8'h00);
      repeat ((8 << f) * 13) @(posedge clk_sys);
      rdc(isc_pkg::OFS_BUS_STAT, 8'h80, 8'h80);
    end
    wr(isc_pkg::OFS_CLK_SEL, 8'h0A);
    rdc(isc_pkg::OFS_BUS_STAT, 8'h80, 8'h00);
    $display("test bus free done");
    // Buffers: overfill, underread, clear, disable
    wr(isc_pkg::OFS_CTRL, EN);
    b = 8'($urandom);
    wr(isc_pkg::OFS_TX_BUF, b);
    chk("txByte", b, txByte);
    chk("dmaTxReq", 8'h00, 8'(dmaTxReq));
    wr(isc_pkg::OFS_TX_BUF, ~b);
    rdc(isc_pkg::OFS_BUF_STAT, 8'hFF, 8'h80);
    chk("txByte", b, txByte);
    chk("forceNack", 8'h01, 8'(forceNack));
    rdc(isc_pkg::OFS_ERR, 8'hFF, 8'h10);
    e = '0;
    e.txTake = 1'b1;
    ev(e);
    rdc(isc_pkg::OFS_BUF_STAT, 8'hFF, 8'hA0);
    chk("txIrqFlag", 8'h01, 8'(txIrqFlag));
    rd(isc_pkg::OFS_RX_BUF, d);
    rdc(isc_pkg::OFS_BUF_STAT, 8'hFF, 8'hA8);
    b = 8'($urandom);
    e = '0;
    e.rxLoad = 1'b1;
    e.rxByte = b;
    ev(e);
    chk("dmaRxReq", 8'h01, 8'(dmaRxReq));
    rdc(isc_pkg::OFS_BUF_STAT, 8'hFF, 8'hA9);
    rdc(isc_pkg::OFS_RX_BUF, 8'hFF, b);
    rdc(isc_pkg::OFS_BUF_STAT, 8'hFF, 8'hA8);
    ev(e);
    wr(isc_pkg::OFS_BUF_STAT, 8'h04);
    rdc(isc_pkg::OFS_BUF_STAT, 8'hFF, 8'h20);
    chk("irqFlags", 8'h00, {6'h00, rxIrqFlag, txIrqFlag});
    wr(isc_pkg::OFS_CTRL, 8'h00);
    wr(isc_pkg::OFS_TX_BUF, b);
    ev(e);
    rdc(isc_pkg::OFS_BUF_STAT, 8'hFF, 8'h20);
    wr(isc_pkg::OFS_CTRL, EN);
    wr(isc_pkg::OFS_ERR, 8'h00);
    $display("test buffers done");
    // Slave and master activity, direction and data flags
    r = 1'($urandom);
    e = '0;
    e.addrMatch = 1'b1;
    e.addrRead = r;
    ev(e);
    rdc(isc_pkg::OFS_BUS_STAT, 8'h78, {3'b010, r, 4'h0});
    e = '0;
    e.byteDone = 1'b1;
    e.byteIsData = 1'b1;
    ev(e);
    rdc(isc_pkg::OFS_BUS_STAT, 8'h78, {3'b010, r, 4'h8});
    isc_bus_peer_inst.stop_cond();
    rdc(isc_pkg::OFS_BUS_STAT, 8'h78, {3'b000, r, 4'h8});
    e = '0;
    e.startSent = 1'b1;
    ev(e);
    rdc(isc_pkg::OFS_BUS_STAT, 8'h78, {3'b001, r, 4'h8});
    e = '0;
    e.stopSent = 1'b1;
    e.byteDone = 1'b1;
    ev(e);
    rdc(isc_pkg::OFS_BUS_STAT, 8'h28, 8'h00);
    e = '0;
    e.addrMatch = 1'b1;
    e.addrKind = isc_pkg::AK_10HIGH;
    e.addrRead = 1'b1;
    ev(e);
    rdc(isc_pkg::OFS_BUS_STAT, 8'h40, 8'h00);
    e.addrKind = isc_pkg::AK_10LOW;
    e.addrRead = 1'b0;
    ev(e);
    rdc(isc_pkg::OFS_BUS_STAT, 8'h50, 8'h40);
    isc_bus_peer_inst.drive(1'b1, 1'b0);
    rdc(isc_pkg::OFS_BUS_STAT, 8'h40, 8'h00);
    e.addrKind = isc_pkg::AK_10HIGH;
    e.addrRead = 1'b1;
    ev(e);
    rdc(isc_pkg::OFS_BUS_STAT, 8'h50, 8'h50);
    // Software idles the slave through the enable bit
    wr(isc_pkg::OFS_CTRL, 8'h00);
    chk("moduleEnable", 8'h00, 8'(moduleEnable));
    rdc(isc_pkg::OFS_BUS_STAT, 8'h60, 8'h00);
    isc_bus_peer_inst.stop_cond();
    $display("test activity done");
    // Collision: peer holds SDA low as SCL rises
    wr(isc_pkg::OFS_CTRL, 8'hC0);
    chk("multiMaster", 8'h01, 8'(multiMaster));
    wr(isc_pkg::OFS_ERR, 8'h02);
    isc_bus_peer_inst.drive(1'b0, 1'b0);
    e = '0;
    e.addrMatch = 1'b1;
    ev(e);
    t0 = idles;
    @(posedge clk_sys);
    seqEv.sdaDrivenHigh <= 1'b1;
    isc_bus_peer_inst.drive(1'b1, 1'b0);
    seqEv <= '0;
    rdc(isc_pkg::OFS_ERR, 8'hFF, 8'h22);
    rdc(isc_pkg::OFS_BUS_STAT, 8'h40, 8'h00);
    chk("goIdle", 8'h01, 8'(idles - t0));
    chk("errIrq", 8'h01, 8'(errIrq));
    isc_bus_peer_inst.drive(1'b1, 1'b1);
    $display("test collision done");
    // Timeout: reserved code, wrong source, then selected source
    wr(isc_pkg::OFS_CTRL, EN);
    wr(isc_pkg::OFS_ERR, 8'h04);
    wr(isc_pkg::OFS_TMO_SEL, 8'h00);
    e = '0;
    e.startSent = 1'b1;
    ev(e);
    tmo(7'h7F);
    rdc(isc_pkg::OFS_ERR, 8'hFF, 8'h04);
    wr(isc_pkg::OFS_TMO_SEL, 8'h03);
    tmo(7'h03);
    rdc(isc_pkg::OFS_ERR, 8'hFF, 8'h04);
    t0 = idles;
    tmo(7'h04);
    rdc(isc_pkg::OFS_ERR, 8'hFF, 8'h44);
    chk("goIdle", 8'h01, 8'(idles - t0));
    chk("errIrq", 8'h01, 8'(errIrq));
    rdc(isc_pkg::OFS_BUS_STAT, 8'h20, 8'h20);
    e = '0;
    e.stopSent = 1'b1;
    ev(e);
    rdc(isc_pkg::OFS_BUS_STAT, 8'h20, 8'h00);
    $display("test timeout done");
    // Random flag and enable mixes into the error request
    for (int i = 0; i < 8; i++) begin
      d = 8'($urandom) & 8'h77;
      wr(isc_pkg::OFS_ERR, d);
      @(posedge clk_sys);
      #1 chk("errIrq", exp_irq(d), 8'(errIrq));
    end
    $display("test error irq done");
    print_verdict();
  end
endmodule
